/* File: verilog/arpf_pkg.sv */
// Shared constants for the asynchronous receive packet formatter
package arpf_pkg;

   // Transaction codes of the serial bus standard
   localparam logic [3:0] TC_WR_QUAD_REQ = 4'h0;
   localparam logic [3:0] TC_WR_BLK_REQ = 4'h1;
   localparam logic [3:0] TC_WR_RESP = 4'h2;
   localparam logic [3:0] TC_RD_QUAD_REQ = 4'h4;
   localparam logic [3:0] TC_RD_BLK_REQ = 4'h5;
   localparam logic [3:0] TC_RD_QUAD_RESP = 4'h6;
   localparam logic [3:0] TC_RD_BLK_RESP = 4'h7;
   localparam logic [3:0] TC_LOCK_REQ = 4'h9;
   localparam logic [3:0] TC_LOCK_RESP = 4'hb;

   // Retry codes, carried through as received
   localparam logic [1:0] RETRY_NEW = 2'h0;
   localparam logic [1:0] RETRY_X = 2'h1;
   localparam logic [1:0] RETRY_A = 2'h2;
   localparam logic [1:0] RETRY_B = 2'h3;

   // Receive speed codes; the fourth code is undefined
   localparam logic [1:0] SPD_100 = 2'h0;
   localparam logic [1:0] SPD_200 = 2'h1;
   localparam logic [1:0] SPD_400 = 2'h2;

   // Field positions inside the quadlets
   localparam int HDR_ID_LSB = 16;
   localparam int STAT_SPD_LSB = 16;
   localparam int LOCK_RCODE_BITS = 4;

   // Values after reset
   localparam logic [31:0] WORD_RST = 32'h0;
   localparam logic [14:0] QCNT_RST = 15'h0;

   // Formatter states, one-hot
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_HDR0 = 7'h02,
      ST_HDR1 = 7'h04,
      ST_HDR2 = 7'h08,
      ST_HDR3 = 7'h10,
      ST_PAY = 7'h20,
      ST_STAT = 7'h40
   } arpf_state_type;

endpackage

/* File: verilog/arpf_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-entry buffer: an output register plus one skid register
module arpf_buffer (
   input wire logic clock,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [31:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [31:0] out_data
);
   logic out_valid_r;
   logic [31:0] out_data_r;
   logic skid_valid_r;
   logic [31:0] skid_data_r;
   logic in_ready_r;
   logic push;
   logic out_load;
   logic skid_valid_nxt;

   // Ready is registered, so the skid entry catches the word sent while it falls
   assign push = in_valid & in_ready_r;
   assign out_load = ~out_valid_r | out_ready;
   assign skid_valid_nxt = out_load ? 1'b0 : (skid_valid_r | push);

   // Output register refills from the skid entry first to keep order
   always_ff @(posedge clock) begin
      if (!rstn) begin
         out_valid_r <= 1'b0;
         out_data_r <= arpf_pkg::WORD_RST;
         skid_valid_r <= 1'b0;
         skid_data_r <= arpf_pkg::WORD_RST;
         in_ready_r <= 1'b0;
      end else begin
         if (out_load) begin
            out_valid_r <= skid_valid_r | push;
            out_data_r <= skid_valid_r ? skid_data_r : in_data;
         end else if (push) begin
            skid_data_r <= in_data;
         end
         skid_valid_r <= skid_valid_nxt;
         in_ready_r <= ~skid_valid_nxt;
      end
   end

   assign in_ready = in_ready_r;
   assign out_valid = out_valid_r;
   assign out_data = out_data_r;
endmodule // arpf_buffer
`default_nettype wire

/* File: verilog/arpf_formatter.sv */
`timescale 1ns/1ps
`default_nettype none
module arpf_formatter (
   input wire logic clock,
   input wire logic rstn,
   input wire logic hdr_valid,
   output logic hdr_ready,
   input wire logic [9:0] dest_bus,
   input wire logic [5:0] dest_node,
   input wire logic [5:0] txn_label,
   input wire logic [1:0] retry_code,
   input wire logic [3:0] txn_code,
   input wire logic [3:0] prio_level,
   input wire logic [15:0] src_node_id,
   input wire logic [15:0] dest_offset_upper,
   input wire logic [31:0] dest_offset_lower,
   input wire logic [31:0] quad_data,
   input wire logic [15:0] byte_count,
   input wire logic [15:0] ext_txn_code,
   input wire logic [1:0] speed_code,
   input wire logic [3:0] ack_returned,
   input wire logic pay_valid,
   output logic pay_ready,
   input wire logic [31:0] pay_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [31:0] rx_data
);
   arpf_pkg::arpf_state_type st_r;
   arpf_pkg::arpf_state_type st_nxt;

   // Captured packet fields
   logic [15:0] dest_id_r;
   logic [15:0] ctrl_r;
   logic [3:0] code_r;
   logic [15:0] src_r;
   logic [15:0] upper_r;
   logic [31:0] lower_r;
   logic [31:0] qdata_r;
   logic [15:0] count_r;
   logic [15:0] ext_r;
   logic [1:0] speed_r;
   logic [3:0] ack_r;
   logic [14:0] qleft_r;
   logic [14:0] qleft_nxt;

   // Staging word in front of the buffer
   logic wr_valid_r;
   logic wr_valid_nxt;
   logic [31:0] wr_data_r;
   logic [31:0] wr_data_nxt;
   logic hdr_ready_r;
   logic pay_ready_r;
   logic pay_ready_nxt;
   logic buf_in_ready;

   logic hdr_take;
   logic pay_take;
   logic stage_free;
   logic hdr_state;
   logic emit;
   logic is_block;
   logic has_data;
   logic is_lock_resp;
   logic last_quad;
   logic [14:0] quad_total;
   logic [11:0] upper_low_keep;
   logic [15:0] upper_fmt;
   logic [31:0] pad_mask;
   logic [31:0] word_hdr0;
   logic [31:0] word_hdr1;
   logic [31:0] word_hdr2;
   logic [31:0] word_hdr3;
   logic [31:0] word_stat;
   logic [31:0] word_emit;

   // Handshakes; both readies are flops so the source sees clean levels
   assign hdr_take = hdr_valid & hdr_ready_r;
   assign pay_take = pay_valid & pay_ready_r;
   assign stage_free = ~wr_valid_r | buf_in_ready;
   assign hdr_state = (st_r == arpf_pkg::ST_HDR0) | (st_r == arpf_pkg::ST_HDR1)
      | (st_r == arpf_pkg::ST_HDR2) | (st_r == arpf_pkg::ST_HDR3)
      | (st_r == arpf_pkg::ST_STAT);
   assign emit = hdr_state & stage_free;

   // Packet class decoded from the captured transaction code
   assign is_block = (code_r == arpf_pkg::TC_WR_BLK_REQ) | (code_r == arpf_pkg::TC_RD_BLK_REQ)
      | (code_r == arpf_pkg::TC_RD_BLK_RESP) | (code_r == arpf_pkg::TC_LOCK_REQ)
      | (code_r == arpf_pkg::TC_LOCK_RESP);
   assign has_data = (code_r == arpf_pkg::TC_WR_QUAD_REQ) | (code_r == arpf_pkg::TC_WR_BLK_REQ)
      | (code_r == arpf_pkg::TC_RD_QUAD_RESP) | (code_r == arpf_pkg::TC_RD_BLK_RESP)
      | (code_r == arpf_pkg::TC_LOCK_REQ) | (code_r == arpf_pkg::TC_LOCK_RESP);
   assign is_lock_resp = code_r == arpf_pkg::TC_LOCK_RESP;

   // Quadlets of payload: byte count rounded up to whole quadlets
   assign quad_total = {1'b0, count_r[15:2]} + {14'h0, |count_r[1:0]};
   assign last_quad = qleft_r == 15'h1;

   // Reserved offset bits of a lock response read as zero
   assign upper_low_keep = is_lock_resp ? 12'h0 : upper_r[11:0];
   assign upper_fmt = {upper_r[15:12], upper_low_keep};

   // Zero bytes past the end of the payload; byte 0 is the top lane
   assign pad_mask = (!last_quad || count_r[1:0] == 2'h0) ? 32'hffffffff :
      (count_r[1:0] == 2'h1) ? 32'hff000000 :
      (count_r[1:0] == 2'h2) ? 32'hffff0000 : 32'hffffff00;

   // Header, length and status words
   assign word_hdr0 = {dest_id_r, ctrl_r};
   assign word_hdr1 = {src_r, upper_fmt};
   assign word_hdr2 = {lower_r[31:2], 2'h0};
   assign word_hdr3 = is_block ? {count_r, ext_r} : qdata_r;
   assign word_stat = {14'h0, speed_r, 12'h0, ack_r};

   // Word chosen for the staging register in each header state
   assign word_emit = (st_r == arpf_pkg::ST_HDR0) ? word_hdr0 :
      (st_r == arpf_pkg::ST_HDR1) ? word_hdr1 :
      (st_r == arpf_pkg::ST_HDR2) ? word_hdr2 :
      (st_r == arpf_pkg::ST_HDR3) ? word_hdr3 : word_stat;

   // Sequence of quadlets through one packet
   always_comb begin
      st_nxt = st_r;
      qleft_nxt = qleft_r;
      case (st_r)
         arpf_pkg::ST_IDLE: begin
            if (hdr_take) begin
               st_nxt = arpf_pkg::ST_HDR0;
            end
         end
         arpf_pkg::ST_HDR0: begin
            if (emit) begin
               st_nxt = arpf_pkg::ST_HDR1;
            end
         end
         arpf_pkg::ST_HDR1: begin
            if (emit) begin
               st_nxt = arpf_pkg::ST_HDR2;
            end
         end
         arpf_pkg::ST_HDR2: begin
            if (emit) begin
               st_nxt = (is_block || has_data) ? arpf_pkg::ST_HDR3 : arpf_pkg::ST_STAT;
            end
         end
         arpf_pkg::ST_HDR3: begin
            qleft_nxt = quad_total;
            if (emit) begin
               // Block read requests, quadlet packets and empty payloads go straight to status
               if (is_block && has_data && quad_total != 15'h0) begin
                  st_nxt = arpf_pkg::ST_PAY;
               end else begin
                  st_nxt = arpf_pkg::ST_STAT;
               end
            end
         end
         arpf_pkg::ST_PAY: begin
            if (pay_take) begin
               qleft_nxt = qleft_r - 15'h1;
               if (last_quad) begin
                  st_nxt = arpf_pkg::ST_STAT;
               end
            end
         end
         arpf_pkg::ST_STAT: begin
            if (emit) begin
               st_nxt = arpf_pkg::ST_IDLE;
            end
         end
         default: begin
            st_nxt = arpf_pkg::ST_IDLE;
         end
      endcase
   end

   // Staging register loads a header word or a payload word
   assign wr_valid_nxt = emit | pay_take | (wr_valid_r & ~buf_in_ready);
   assign wr_data_nxt = emit ? word_emit :
      pay_take ? (pay_data & pad_mask) : wr_data_r;

   // Payload ready only while the stage stays empty; costs rate, keeps the
   // ready a plain flop with no path from the sink
   assign pay_ready_nxt = (st_nxt == arpf_pkg::ST_PAY) & ~wr_valid_nxt;

   // State and handshake flops
   always_ff @(posedge clock) begin
      if (!rstn) begin
         st_r <= arpf_pkg::ST_IDLE;
         qleft_r <= arpf_pkg::QCNT_RST;
         wr_valid_r <= 1'b0;
         wr_data_r <= arpf_pkg::WORD_RST;
         hdr_ready_r <= 1'b0;
         pay_ready_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         qleft_r <= qleft_nxt;
         wr_valid_r <= wr_valid_nxt;
         wr_data_r <= wr_data_nxt;
         hdr_ready_r <= st_nxt == arpf_pkg::ST_IDLE;
         pay_ready_r <= pay_ready_nxt;
      end
   end

   // Field capture when a header is accepted; fields pass unchanged
   always_ff @(posedge clock) begin
      if (!rstn) begin
         dest_id_r <= 16'h0;
         ctrl_r <= 16'h0;
         code_r <= 4'h0;
         src_r <= 16'h0;
         upper_r <= 16'h0;
         lower_r <= arpf_pkg::WORD_RST;
         qdata_r <= arpf_pkg::WORD_RST;
         count_r <= 16'h0;
         ext_r <= 16'h0;
         speed_r <= 2'h0;
         ack_r <= 4'h0;
      end else if (hdr_take) begin
         dest_id_r <= {dest_bus, dest_node};
         ctrl_r <= {txn_label, retry_code, txn_code, prio_level};
         code_r <= txn_code;
         src_r <= src_node_id;
         upper_r <= dest_offset_upper;
         lower_r <= dest_offset_lower;
         qdata_r <= quad_data;
         count_r <= byte_count;
         ext_r <= ext_txn_code;
         speed_r <= speed_code;
         ack_r <= ack_returned;
      end
   end

   // Output buffer absorbs a receiver stall without losing a word
   arpf_buffer u_buffer (
      .clock(clock),
      .rstn(rstn),
      .in_valid(wr_valid_r),
      .in_ready(buf_in_ready),
      .in_data(wr_data_r),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data)
   );

   assign hdr_ready = hdr_ready_r;
   assign pay_ready = pay_ready_r;

   // Checks on the staged words and on the state sequence
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   property p_dest_id;
      hdr_take |=> ##1 (wr_data_r[31:16] == {$past(dest_bus, 2), $past(dest_node, 2)});
   endproperty
   a_dest_id: assert property (p_dest_id)
      else $error("destination id not in first quadlet");

   property p_ctrl;
      (st_r == arpf_pkg::ST_HDR0) && emit |=> wr_data_r[15:0] == ctrl_r;
   endproperty
   a_ctrl: assert property (p_ctrl)
      else $error("control fields altered");

   property p_src;
      (st_r == arpf_pkg::ST_HDR1) && emit |=> wr_data_r[31:16] == src_r;
   endproperty
   a_src: assert property (p_src)
      else $error("source id not in second quadlet");

   property p_align;
      (st_r == arpf_pkg::ST_HDR2) && emit |=>
         wr_data_r == {lower_r[31:2], 2'h0} && wr_valid_r;
   endproperty
   a_align: assert property (p_align)
      else $error("offset low not quadlet aligned");

   property p_lock;
      (st_r == arpf_pkg::ST_HDR1) && emit && is_lock_resp |=>
         wr_data_r[15:0] == {upper_r[15:12], 12'h0};
   endproperty
   a_lock: assert property (p_lock)
      else $error("lock response reserved bits not zero");

   property p_no_data;
      (st_r == arpf_pkg::ST_HDR2) && emit && !is_block && !has_data |=>
         st_r == arpf_pkg::ST_STAT;
   endproperty
   a_no_data: assert property (p_no_data)
      else $error("quadlet data emitted for a packet without data");

   property p_length;
      (st_r == arpf_pkg::ST_HDR3) && emit && is_block |=> wr_data_r == {count_r, ext_r};
   endproperty
   a_length: assert property (p_length)
      else $error("length quadlet malformed");

   property p_status;
      (st_r == arpf_pkg::ST_STAT) && emit |=> wr_data_r[31:18] == 14'h0
         && wr_data_r[15:4] == 12'h0 && wr_data_r[3:0] == ack_r
         && wr_data_r[17:16] == speed_r && hdr_ready_r;
   endproperty
   a_status: assert property (p_status)
      else $error("status quadlet malformed");

   property p_pad;
      pay_take && last_quad && count_r[1:0] == 2'h1 |=> wr_data_r[23:0] == 24'h0;
   endproperty
   a_pad: assert property (p_pad)
      else $error("last payload quadlet not zero padded");

   property p_pay_count;
      (st_r == arpf_pkg::ST_HDR3) && emit && is_block && has_data && quad_total == 15'h1
         |=> (st_r == arpf_pkg::ST_PAY) [*1] ##0 qleft_r == 15'h1;
   endproperty
   a_pay_count: assert property (p_pay_count)
      else $error("payload quadlet count wrong");

   property p_pay_safe;
      pay_ready_r |-> !wr_valid_r && st_r == arpf_pkg::ST_PAY;
   endproperty
   a_pay_safe: assert property (p_pay_safe)
      else $error("payload accepted while stage busy");

endmodule // arpf_formatter
`default_nettype wire

/* File: testbench/arpf_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side of the receive FIFO: takes quadlets, sometimes slowly
module arpf_sink (
   input wire logic clock,
   input wire logic rstn,
   input wire logic stall_en,
   input wire logic hold_off,
   input wire logic rx_valid,
   input wire logic [31:0] rx_data,
   output logic rx_ready
);
   logic [31:0] words[$];

   initial rx_ready = 1'b0;

   // Ready moves only just after an edge; random gaps fill the two-entry buffer
   always @(posedge clock) begin
      if (rstn && rx_valid && rx_ready) begin
         words.push_back(rx_data);
      end
      if (!rstn || hold_off) begin
         rx_ready <= 1'b0;
      end else begin
         rx_ready <= stall_en ? ($urandom_range(0, 2) == 0) : 1'b1;
      end
   end
endmodule // arpf_sink
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic hdr_valid = 1'b0, pay_valid = 1'b0, stall_en = 1'b0, hold_off = 1'b0;
   logic [9:0] dest_bus = 10'h0;
   logic [5:0] dest_node = 6'h0, txn_label = 6'h0;
   logic [1:0] retry_code = 2'h0, speed_code = 2'h0;
   logic [3:0] txn_code = 4'h0, prio_level = 4'h0, ack_returned = 4'h0;
   logic [15:0] src_node_id = 16'h0, dest_offset_upper = 16'h0;
   logic [15:0] byte_count = 16'h0, ext_txn_code = 16'h0;
   logic [31:0] dest_offset_lower = 32'h0, quad_data = 32'h0, pay_data = 32'h0;
   logic hdr_ready, pay_ready, rx_valid, rx_ready;
   logic [31:0] rx_data;
   int n_errors = 0;
   int comparisons = 0;
   logic [31:0] exp_q[$];
   logic [31:0] pay_q[$];
   logic [3:0] codes[10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hb, 4'h3};
   logic [15:0] lens[10] = '{16'h0, 16'h5, 16'h0, 16'h0, 16'h10, 16'h4, 16'h3, 16'h8,
      16'h2, 16'h6};

   always #4 clock = ~clock;

   arpf_formatter dut (.clock(clock), .rstn(rstn), .hdr_valid(hdr_valid),
      .hdr_ready(hdr_ready), .dest_bus(dest_bus), .dest_node(dest_node),
      .txn_label(txn_label), .retry_code(retry_code), .txn_code(txn_code),
      .prio_level(prio_level), .src_node_id(src_node_id),
      .dest_offset_upper(dest_offset_upper), .dest_offset_lower(dest_offset_lower),
      .quad_data(quad_data), .byte_count(byte_count), .ext_txn_code(ext_txn_code),
      .speed_code(speed_code), .ack_returned(ack_returned), .pay_valid(pay_valid),
      .pay_ready(pay_ready), .pay_data(pay_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_data(rx_data));

   arpf_sink snk (.clock(clock), .rstn(rstn), .stall_en(stall_en), .hold_off(hold_off),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready));

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         n_errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask

   task automatic give_verdict;
      $display("Errors %0d, comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // One packet: random fields, expected quadlets, header and payload in parallel
   task automatic send_pkt(input logic [3:0] code, input logic [15:0] bc,
         input logic [1:0] rt, input logic [1:0] spd, input logic stall);
      int i;
      int nw;
      logic [31:0] d;
      logic blk;
      @(negedge clock);
      stall_en = stall;
      txn_code = code;
      byte_count = bc;
      retry_code = rt;
      speed_code = spd;
      dest_bus = 10'($urandom);
      dest_node = 6'($urandom);
      txn_label = 6'($urandom);
      prio_level = 4'($urandom);
      src_node_id = 16'($urandom);
      dest_offset_upper = 16'($urandom);
      dest_offset_lower = $urandom;
      quad_data = $urandom;
      ext_txn_code = 16'($urandom);
      ack_returned = 4'($urandom);
      blk = code inside {4'h1, 4'h5, 4'h7, 4'h9, 4'hb};
      exp_q = {};
      pay_q = {};
      exp_q.push_back({dest_bus, dest_node, txn_label, rt, code, prio_level});
      exp_q.push_back({src_node_id, (code == arpf_pkg::TC_LOCK_RESP) ?
         {dest_offset_upper[15:12], 12'h0} : dest_offset_upper});
      exp_q.push_back({dest_offset_lower[31:2], 2'b00});
      if (code == arpf_pkg::TC_WR_QUAD_REQ || code == arpf_pkg::TC_RD_QUAD_RESP) begin
         exp_q.push_back(quad_data);
      end
      if (blk) exp_q.push_back({bc, ext_txn_code});
      nw = (blk && code != arpf_pkg::TC_RD_BLK_REQ) ? (int'(bc) + 3) / 4 : 0;
      for (i = 0; i < nw; i++) begin
         d = $urandom;
         pay_q.push_back(d);
         if (i == nw - 1 && bc[1:0] != 2'b00) d = d & (32'hffffffff << (8 * (4 - int'(bc[1:0]))));
         exp_q.push_back(d);
      end
      exp_q.push_back({14'h0, spd, 12'h0, ack_returned});
      snk.words = {};
      hdr_valid = 1'b1;
      fork
         begin
            while (!hdr_ready) @(negedge clock);
            @(posedge clock);
            @(negedge clock);
            // Fields change after the take; a late sample would show up
            hdr_valid = 1'b0;
            quad_data = ~quad_data;
            dest_offset_lower = ~dest_offset_lower;
            ack_returned = ~ack_returned;
         end
         begin
            foreach (pay_q[k]) begin
               pay_valid = 1'b1;
               pay_data = pay_q[k];
               while (!pay_ready) @(negedge clock);
               @(posedge clock);
               @(negedge clock);
            end
            pay_valid = 1'b0;
         end
      join
      i = 0;
      while (snk.words.size() < exp_q.size() && i < 400) begin
         @(negedge clock);
         i++;
      end
      repeat (4) @(negedge clock);
      check(32'(snk.words.size()), 32'(exp_q.size()));
      if (snk.words.size() == exp_q.size()) begin
         check(snk.words[0], exp_q[0]);
         check(snk.words[1], exp_q[1]);
         check(snk.words[2], exp_q[2]);
         for (i = 3; i < exp_q.size() - 1; i++) begin
            check(snk.words[i], exp_q[i]);
         end
         check(snk.words[i], exp_q[i]);
      end
   endtask

   // Main sequence: every code once, a long stall, then random traffic
   initial begin
      void'($urandom(32'hce4d));
      repeat (10) @(negedge clock);
      check({30'h0, hdr_ready, rx_valid}, 32'h0);
      rstn = 1'b1;
      foreach (codes[k]) send_pkt(codes[k], lens[k], 2'(k), 2'(k % 3), 1'b0);
      // Host stops reading before the packet starts and resumes 24 cycles later; nothing may be lost
      fork
         send_pkt(4'h1, 16'h1d, 2'h3, 2'h2, 1'b1);
         begin
            hold_off = 1'b1;
            repeat (24) @(negedge clock);
            check({31'h0, rx_valid}, 32'h1);
            hold_off = 1'b0;
         end
      join
      repeat (40) begin
         send_pkt(codes[$urandom_range(0, 9)], 16'($urandom_range(0, 24)), 2'($urandom),
            2'($urandom_range(0, 2)), 1'($urandom));
      end
      give_verdict();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #200000;
      n_errors++;
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
